/* File: design/rco_defs.svh */
`ifndef RCO_DEFS_SVH
`define RCO_DEFS_SVH

// Register bus geometry
`define RCO_ADDR_W 4
`define RCO_DATA_W 16

// Register offsets
`define RCO_CTRL_OFS 4'h0
`define RCO_STAT_OFS 4'h4
`define RCO_PCNT_OFS 4'h8

// Control register fields
`define RCO_EN_BIT 7
`define RCO_DC_HI 4
`define RCO_DC_LO 3
`define RCO_DIV_HI 2
`define RCO_DIV_LO 0
`define RCO_CTRL_RST 8'h10

// Status register fields
`define RCO_ST_RUN_BIT 0
`define RCO_ST_LVL_BIT 1
`define RCO_ST_SLP_BIT 2
`define RCO_ST_BYP_BIT 3
`define RCO_ST_PH_LO 8

// Divider and period counter geometry
`define RCO_DIV_W 3
`define RCO_CNT_W 7
`define RCO_PCNT_W 16

`endif

/* File: design/rco_pkg.sv */
`include "rco_defs.svh"

package rco_pkg;

   typedef struct packed {
      logic enable;
      logic [1:0] duty;
      logic [`RCO_DIV_W-1:0] div;
   } rco_ctrl_s;

   typedef struct packed {
      logic [`RCO_ADDR_W-1:0] addr;
      logic [`RCO_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } rco_bus_s;

   typedef enum logic [1:0] {
      RCO_IDLE = 2'h0,
      RCO_RUN = 2'h1,
      RCO_HOLD = 2'h3
   } rco_state_e;

endpackage

/* File: design/rco_wave.sv */
`timescale 1ns/1ps
`include "rco_defs.svh"

module rco_wave #(
   parameter int DIV_W = `RCO_DIV_W,
   parameter int CNT_W = `RCO_CNT_W
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_run,
   input wire logic i_restart,
   input wire logic i_freeze,
   input wire logic [DIV_W-1:0] i_div,
   input wire logic [1:0] i_duty,
   output logic o_wave,
   output logic o_period_end,
   output logic [CNT_W-1:0] o_phase
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] nxt;
   logic [CNT_W-1:0] mask;
   logic [CNT_W:0] span;
   logic [CNT_W+2:0] prod;
   logic [CNT_W:0] thr;
   logic wrap;
   logic high_d;

   // Period mask 2^div - 1
   always_comb begin
      span = (CNT_W+1)'(1) << i_div;
      mask = CNT_W'(span - (CNT_W+1)'(1));
   end

   // R6 duty fraction
   // High time is floor(N*duty/4), at least one cycle when duty is nonzero;
   // product kept wide so three times the longest period fits
   always_comb begin
      prod = (CNT_W+3)'(span) * (CNT_W+3)'(i_duty);
      thr = (CNT_W+1)'(prod >> 2);
      if (i_duty != 2'h0 && thr == '0) begin
         thr = (CNT_W+1)'(1);
      end
   end

   // Masking keeps a live divider change inside the new period
   assign wrap = (cnt_q & mask) == mask;
   // Level is that of the slot being entered, so output and count agree
   assign nxt = wrap ? '0 : cnt_q + CNT_W'(1);

   // R13 high then low
   assign high_d = (CNT_W+1)'(nxt & mask) < thr;

   // R2 restart at zero
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= '0;
      end else if (i_restart || !i_run) begin
         cnt_q <= '0;
      end else if (!i_freeze) begin
         cnt_q <= nxt;
      end
   end

   // R3 drop at once
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_wave <= 1'b0;
      end else if (!i_run) begin
         o_wave <= 1'b0;
      end else if (i_restart) begin
         o_wave <= i_duty != 2'h0;
      end else if (!i_freeze) begin
         // R9 level frozen
         o_wave <= high_d;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_period_end <= 1'b0;
      end else begin
         o_period_end <= i_run && !i_restart && !i_freeze && wrap;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_phase <= '0;
      end else begin
         o_phase <= cnt_q;
      end
   end

endmodule

/* File: design/rco_top.sv */
`timescale 1ns/1ps
`include "rco_defs.svh"

//
// Contract
// R1 - Output derived only from the system clock; clock changes show directly.
// R2 - Setting enable starts output without runt or shortened pulse.
// R3 - Clearing enable stops the output immediately, mid period.
// R4 - Live divider and duty changes accepted; may glitch; change while off.
// R5 - Divider select gives system clock divided by two to the field.
// R6 - Duty select 11/10/01/00 gives 75/50/25/0 percent high time; at divide by two, 11 and 01 both give 50 percent.
// R7 - Duty ignored when undivided; output then follows the system clock.
// R8 - Duty select resets to binary 10, fifty percent.
// R9 - During sleep the output holds its present level; the undivided output is gated low at the next falling edge instead.
// R10 - Generated clock also routed internally to other peripherals.
// R11 - Control: enable bit 7, 6-5 read zero, duty 4-3, divider 2-0.
// R12 - Reset clears enable and divider select: disabled, undivided.
// R13 - Divided output high at period start for the duty fraction.
module rco_top (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [`RCO_ADDR_W-1:0] i_addr,
   input wire logic [`RCO_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_sleep,
   output logic [`RCO_DATA_W-1:0] o_rdata,
   output logic o_ref_clock_out_pin,
   output logic o_refclk_internal,
   output rco_pkg::rco_ctrl_s o_ctrl
);
   import rco_pkg::*;

   rco_bus_s bus;
   rco_ctrl_s ctrl_q;
   rco_state_e state_q;
   rco_state_e state_d;
   logic restart;
   logic run;
   logic freeze;
   logic bypass;
   logic gate_q;
   logic wave;
   logic period_end;
   logic [`RCO_CNT_W-1:0] phase;
   logic [`RCO_PCNT_W-1:0] pcnt_q;
   logic [`RCO_DATA_W-1:0] rdata_d;
   logic ctrl_wr;
   logic pcnt_wr;
   logic level;

   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
   assign ctrl_wr = bus.wr && bus.addr == `RCO_CTRL_OFS;
   assign pcnt_wr = bus.wr && bus.addr == `RCO_PCNT_OFS;
   assign bypass = ctrl_q.div == '0;

   // R12 reset values
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q.enable <= 1'b0;
         ctrl_q.div <= '0;
      end else if (ctrl_wr) begin
         // R11 field layout
         ctrl_q.enable <= bus.wdata[`RCO_EN_BIT];
         // R4 live change taken
         ctrl_q.div <= bus.wdata[`RCO_DIV_HI:`RCO_DIV_LO];
      end
   end

   // R8 duty resets to 50%
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q.duty <= 2'(`RCO_CTRL_RST >> `RCO_DC_LO);
      end else if (ctrl_wr) begin
         ctrl_q.duty <= bus.wdata[`RCO_DC_HI:`RCO_DC_LO];
      end
   end

   // Enable, sleep and run sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RCO_IDLE: begin
            if (ctrl_q.enable) begin
               state_d = RCO_RUN;
            end
         end
         RCO_RUN: begin
            if (!ctrl_q.enable) begin
               state_d = RCO_IDLE;
            end else if (i_sleep) begin
               state_d = RCO_HOLD;
            end
         end
         RCO_HOLD: begin
            if (!ctrl_q.enable) begin
               state_d = RCO_IDLE;
            end else if (!i_sleep) begin
               state_d = RCO_RUN;
            end
         end
         default: begin
            state_d = RCO_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= RCO_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // R2 clean first period
   assign restart = state_q == RCO_IDLE && ctrl_q.enable;
   // R3 enable gates the run
   assign run = ctrl_q.enable;
   // R9 freeze in sleep
   assign freeze = i_sleep && state_q != RCO_IDLE;

   // R5 power-of-two divide
   rco_wave #(
      .DIV_W(`RCO_DIV_W),
      .CNT_W(`RCO_CNT_W)
   ) u_wave (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_run(run),
      .i_restart(restart),
      .i_freeze(freeze),
      .i_div(ctrl_q.div),
      .i_duty(ctrl_q.duty),
      .o_wave(wave),
      .o_period_end(period_end),
      .o_phase(phase)
   );

   // Undivided gate changes on the falling edge so no runt can reach
   // the output; the bypass AND below is the only place the clock feeds data.
   always_ff @(negedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gate_q <= 1'b0;
      end else begin
         // R7 duty ignored
         gate_q <= ctrl_q.enable && bypass && !freeze;
      end
   end

   // R1 system clock source
   assign level = bypass ? (i_clk & gate_q) : wave;
   // R10 internal copy
   assign o_ref_clock_out_pin = level;
   assign o_refclk_internal = level;

   // Completed periods, cleared by a write to its offset unless a period ends in that cycle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pcnt_q <= '0;
      end else if (period_end) begin
         pcnt_q <= pcnt_q + `RCO_PCNT_W'(1);
      end else if (pcnt_wr) begin
         pcnt_q <= '0;
      end
   end

   // R11 reserved bits read zero
   always_comb begin
      rdata_d = '0;
      unique case (bus.addr)
         `RCO_CTRL_OFS: begin
            rdata_d[`RCO_EN_BIT] = ctrl_q.enable;
            rdata_d[`RCO_DC_HI:`RCO_DC_LO] = ctrl_q.duty;
            rdata_d[`RCO_DIV_HI:`RCO_DIV_LO] = ctrl_q.div;
         end
         `RCO_STAT_OFS: begin
            rdata_d[`RCO_ST_RUN_BIT] = state_q == RCO_RUN;
            rdata_d[`RCO_ST_LVL_BIT] = wave;
            rdata_d[`RCO_ST_SLP_BIT] = state_q == RCO_HOLD;
            rdata_d[`RCO_ST_BYP_BIT] = bypass;
            rdata_d[`RCO_ST_PH_LO +: `RCO_CNT_W] = phase;
         end
         `RCO_PCNT_OFS: begin
            rdata_d = pcnt_q;
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
      end else if (bus.rd) begin
         o_rdata <= rdata_d;
      end else begin
         o_rdata <= '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ctrl <= '{enable: 1'b0, duty: 2'h2, div: '0};
      end else begin
         o_ctrl <= ctrl_q;
      end
   end

endmodule

/* File: verification/rco_sink.sv */
`timescale 1ns/1ps
module rco_sink (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_ref,
   output logic [15:0] o_rises
);
   logic ref_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ref_q <= 1'b0;
         o_rises <= 16'h0000;
      end else begin
         ref_q <= i_ref;
         if (i_ref && !ref_q) begin
            o_rises <= o_rises + 16'h0001;
         end
      end
   end
endmodule

/* File: verification/rco_top_asserts.sv */
`timescale 1ns/1ps
module rco_top_asserts (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_sleep,
   input wire logic [15:0] o_rdata,
   input wire logic o_ref_clock_out_pin,
   input wire logic o_refclk_internal,
   input wire rco_pkg::rco_ctrl_s o_ctrl
);
   import rco_pkg::*;
   wire ck = o_ref_clock_out_pin;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   AST_RST_CTRL: assert property (
      $rose(i_reset_n) |-> o_ctrl == 6'h10)
      else $error("ctrl reset value");
   AST_WR_CTRL: assert property (
      $past(i_wr, 2) && $past(i_addr, 2) == 4'h0 |->
      o_ctrl == {$past(i_wdata[7], 2), $past(i_wdata[4:0], 2)})
      else $error("ctrl write");
   AST_RD_IDLE: assert property (
      !$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("rdata not idle");
   AST_COPY: assert property (
      o_refclk_internal == ck)
      else $error("internal copy differs");
   AST_OFF_LOW: assert property (
      !o_ctrl.enable && !$past(o_ctrl.enable) |-> !ck)
      else $error("out while disabled");
   AST_STOP: assert property (
      $fell(o_ctrl.enable) |-> !ck)
      else $error("late stop");
   AST_START: assert property (
      $rose(o_ctrl.enable) && o_ctrl.div != 3'h0 &&
      o_ctrl.duty != 2'h0 && !i_sleep |-> ck)
      else $error("start not high");
   AST_DUTY0: assert property (
      o_ctrl.enable && $past(o_ctrl.enable) && o_ctrl.div != 3'h0 &&
      o_ctrl.duty == 2'h0 |=> !ck)
      else $error("duty zero high");
   AST_DIV2: assert property (
      o_ctrl.enable && $past(o_ctrl.enable, 2) && o_ctrl.div == 3'h1 &&
      o_ctrl.duty != 2'h0 && !$past(i_sleep) |-> ck != $past(ck))
      else $error("div2 not toggling");
   // Two sleep samples tolerate a registered sleep input
   AST_SLEEP: assert property (
      $past(i_sleep) && $past(i_sleep, 2) && o_ctrl.enable &&
      $past(o_ctrl.enable) && o_ctrl.div != 3'h0 |-> $stable(ck))
      else $error("sleep not holding");
endmodule

bind rco_top rco_top_asserts u_chk (
   .i_clk(i_clk),
   .i_reset_n(i_reset_n),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .i_wr(i_wr),
   .i_rd(i_rd),
   .i_sleep(i_sleep),
   .o_rdata(o_rdata),
   .o_ref_clock_out_pin(o_ref_clock_out_pin),
   .o_refclk_internal(o_refclk_internal),
   .o_ctrl(o_ctrl)
);

/* File: verification/rco_top_tb.sv */
`timescale 1ns/1ps
module rco_top_tb;
   import rco_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_sleep = 1'b0;
   logic [15:0] o_rdata;
   logic out;
   logic ref_int;
   logic lvl;
   rco_ctrl_s o_ctrl;
   logic [15:0] rises;
   int n_fail = 0;
   int total_checks = 0;
   always #2.5 i_clk = ~i_clk;
   rco_top dut (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .i_sleep(i_sleep),
      .o_rdata(o_rdata),
      .o_ref_clock_out_pin(out),
      .o_refclk_internal(ref_int),
      .o_ctrl(o_ctrl)
   );
   rco_sink u_sink (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_ref(ref_int),
      .o_rises(rises)
   );
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e,
                     input string nm);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk(nm, e, o_rdata);
   endtask
   // two periods, settings changed only while stopped
   task automatic run(input logic [2:0] dv, input logic [1:0] dc);
      int n;
      int h;
      logic [15:0] cnt;
      logic [15:0] r0;
      n = 1 << dv;
      h = (n * dc) / 4;
      if (dc != 2'h0 && h == 0) begin
         h = 1;
      end
      cnt = 16'h0000;
      r0 = rises;
      wr(4'h0, {8'h00, 1'b1, 2'h0, dc, dv});
      repeat (1) @(posedge i_clk);
      for (int i = 0; i < 2 * n; i++) begin
         @(negedge i_clk);
         if (i == 0) begin
            chk("start", 16'(dc != 2'h0), 16'(out));
         end
         cnt = cnt + 16'(out);
      end
      chk("high", 16'(2 * h), cnt);
      chk("rises", dc != 2'h0 ? 16'h0002 : 16'h0000, rises - r0);
      wr(4'h0, {8'h00, 1'b0, 2'h0, dc, dv});
      repeat (1) @(posedge i_clk);
      @(negedge i_clk);
      chk("stop", 16'h0000, 16'(out));
      $display("test div %0d duty %0d done", dv, dc);
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rd(4'h0, 16'h0010, "ctrl reset");
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h009f, "ctrl fields");
      rd(4'hc, 16'h0000, "unmapped");
      wr(4'h0, 16'h0010);
      for (int d = 1; d < 8; d++) begin
         run(3'(d), 2'h2);
      end
      for (int c = 0; c < 4; c++) begin
         run(3'h3, 2'(c));
      end
      wr(4'h8, 16'h0000);
      run(3'h2, 2'h2);
      rd(4'h8, 16'h0002, "periods");
      wr(4'h0, 16'h0080);
      repeat (4) @(posedge i_clk);
      #1;
      chk("bypass high", 16'h0001, 16'(out));
      @(negedge i_clk);
      #1;
      chk("bypass low", 16'h0000, 16'(out));
      rd(4'h4, 16'h0009, "status bypass");
      wr(4'h0, 16'h0010);
      // Sleep lands on the last high cycle, so a leak shows as low
      wr(4'h0, 16'h0093);
      repeat (4) @(posedge i_clk);
      i_sleep <= 1'b1;
      @(negedge i_clk);
      lvl = out;
      repeat (12) @(negedge i_clk);
      chk("sleep hold", 16'h0001, 16'(lvl & out));
      @(posedge i_clk);
      i_sleep <= 1'b0;
      wr(4'h0, 16'h0010);
      wr(4'h0, 16'h009b);
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rd(4'h0, 16'h0010, "ctrl re-reset");
      $display("test misc done");
      tally_and_finish;
   end
   // Whole sequence needs about seven hundred cycles
   initial begin
      #50000;
      n_fail++;
      tally_and_finish;
   end
endmodule
